// File: common/msbc_pkg.sv
// shared constants for the module sideband control block
package msbc_pkg;
	// reset filter: least low time on the module reset pin, in ns
	localparam int RST_MIN_NS        = 2000;
	localparam int SYS_CLK_MHZ       = 10;
	// least time rounds up to whole cycles
	localparam int RST_MIN_CYC       = (RST_MIN_NS * SYS_CLK_MHZ + 999) / 1000;
	// management interface bring-up time after reset, in ns
	localparam int MGMT_INIT_NS      = 5000;
	localparam int MGMT_INIT_CYC     = (MGMT_INIT_NS * SYS_CLK_MHZ + 999) / 1000;
	localparam int CNT_W             = 16;
	// status byte layout seen by the serial slave
	localparam int STAT_NOT_READY    = 0;
	localparam int STAT_HIGH_POWER   = 1;
	localparam int STAT_INIT_SW      = 2;
	localparam int STAT_W            = 8;
	// reset values
	localparam logic [7:0] STAT_RST  = 8'h01;

	typedef enum logic [3:0] {
		MSBC_ST_RESET    = 4'h1,
		MSBC_ST_INIT     = 4'h2,
		MSBC_ST_LOWPWR   = 4'h4,
		MSBC_ST_HIGHPWR  = 4'h8
	} msbc_state_t;
endpackage : msbc_pkg

// File: hw/msbc_reset_filter.sv
// glitch filter on the synchronised module reset pin
module msbc_reset_filter #(
	parameter int MIN_CYC = msbc_pkg::RST_MIN_CYC
) (
	input  wire logic i_sys_clk,
	input  wire logic i_nrst,
	input  wire logic i_level_n,
	output logic      o_reset_pulse
);
	logic [msbc_pkg::CNT_W-1:0] cnt_reg;
	logic [msbc_pkg::CNT_W-1:0] cnt_next;
	logic                       pulse_reg;
	logic                       pulse_next;

	// count low time; pulse once when it reaches the minimum
	always_comb
	begin
		cnt_next   = cnt_reg;
		pulse_next = 1'b0;
		if (i_level_n)
			cnt_next = '0;
		else if (cnt_reg < MIN_CYC[msbc_pkg::CNT_W-1:0])
		begin
			cnt_next = cnt_reg + 16'h0001;
			if (cnt_next == MIN_CYC[msbc_pkg::CNT_W-1:0])
				pulse_next = 1'b1;
		end
	end

	// state registers
	always_ff @(posedge i_sys_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			cnt_reg   <= '0;
			pulse_reg <= 1'b0;
		end
		else
		begin
			cnt_reg   <= cnt_next;
			pulse_reg <= pulse_next;
		end
	end

	assign o_reset_pulse = pulse_reg;
endmodule // msbc_reset_filter

// File: hw/msbc_sideband.sv
// sideband control and status logic of a pluggable module
// Contract
// - serial bus answered only while selected
// - long reset low restores all defaults; the interrupt and the init-mode status bit keep their values
// - completion: interrupt low, not-ready cleared
// - completion interrupt also after power-up
// - init select reads high when undriven
// - select high: stay low power until software
// - select low: high power after init
// - present line tied to ground
// - interrupt low flags fault or status
// - interrupt only pulled low, never high
module msbc_sideband #(
	parameter int RST_MIN_CYC   = msbc_pkg::RST_MIN_CYC,
	parameter int MGMT_INIT_CYC = msbc_pkg::MGMT_INIT_CYC
) (
	input  wire logic                       i_sys_clk,
	input  wire logic                       i_nrst,
	input  wire logic                       i_module_select_n,
	input  wire logic                       i_module_reset_n,
	input  wire logic                       i_init_control_select,
	input  wire logic                       i_init_select_driven,
	input  wire logic                       i_scl,
	input  wire logic                       i_sda,
	input  wire logic                       i_sw_high_power,
	input  wire logic                       i_fault,
	input  wire logic                       i_status_read,
	output logic                            o_scl_enable,
	output logic                            o_sda_enable,
	output logic [msbc_pkg::STAT_W-1:0]     o_status,
	output logic                            o_high_power,
	output logic                            o_module_present_n,
	output logic                            o_module_present_oe,
	output logic                            o_interrupt_n,
	output logic                            o_interrupt_oe,
	output logic                            o_defaults_load
);
	logic [2:0]                 sel_sync_reg;
	logic [2:0]                 sel_sync_next;
	logic [1:0]                 rst_sync_reg;
	logic [1:0]                 rst_sync_next;
	logic [1:0]                 ini_sync_reg;
	logic [1:0]                 ini_sync_next;
	logic [1:0]                 drv_sync_reg;
	logic [1:0]                 drv_sync_next;
	logic [1:0]                 scl_sync_reg;
	logic [1:0]                 scl_sync_next;
	logic [1:0]                 sda_sync_reg;
	logic [1:0]                 sda_sync_next;
	logic                       rst_pulse;
	msbc_pkg::msbc_state_t      state_reg;
	msbc_pkg::msbc_state_t      state_next;
	logic [msbc_pkg::CNT_W-1:0] cnt_reg;
	logic [msbc_pkg::CNT_W-1:0] cnt_next;
	logic                       not_ready_reg;
	logic                       not_ready_next;
	logic                       done_int_reg;
	logic                       done_int_next;
	logic                       init_sw_reg;
	logic                       init_sw_next;
	logic                       bus_en_reg;
	logic                       bus_en_next;
	logic                       int_oe_reg;
	logic                       int_oe_next;
	logic                       defaults_reg;
	logic                       defaults_next;
	logic [msbc_pkg::STAT_W-1:0] status_reg;
	logic [msbc_pkg::STAT_W-1:0] status_next;
	logic                       hp_reg;
	logic                       hp_next;
	logic [msbc_pkg::CNT_W-1:0] low_run_reg;
	logic [msbc_pkg::CNT_W-1:0] low_run_next;

	// two-flop synchronisers for the pin inputs, three flops on module select
	always_comb
	begin
		sel_sync_next = {sel_sync_reg[1:0], i_module_select_n};
		rst_sync_next = {rst_sync_reg[0], i_module_reset_n};
		ini_sync_next = {ini_sync_reg[0], i_init_control_select};
		drv_sync_next = {drv_sync_reg[0], i_init_select_driven};
		scl_sync_next = {scl_sync_reg[0], i_scl};
		sda_sync_next = {sda_sync_reg[0], i_sda};
		// saturating low-time count, the yardstick for the filter check
		low_run_next  = rst_sync_reg[1] ? '0 : low_run_reg + {15'h0000, ~&low_run_reg};
	end

	always_ff @(posedge i_sys_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			sel_sync_reg <= 3'h7;
			rst_sync_reg <= 2'h3;
			ini_sync_reg <= 2'h3;
			drv_sync_reg <= 2'h0;
			scl_sync_reg <= 2'h3;
			sda_sync_reg <= 2'h3;
			low_run_reg  <= '0;
		end
		else
		begin
			sel_sync_reg <= sel_sync_next;
			rst_sync_reg <= rst_sync_next;
			ini_sync_reg <= ini_sync_next;
			drv_sync_reg <= drv_sync_next;
			scl_sync_reg <= scl_sync_next;
			sda_sync_reg <= sda_sync_next;
			low_run_reg  <= low_run_next;
		end
	end

	msbc_reset_filter #(
		.MIN_CYC       (RST_MIN_CYC)
	) u_rst_filter (
		.i_sys_clk     (i_sys_clk),
		.i_nrst        (i_nrst),
		.i_level_n     (rst_sync_reg[1]),
		.o_reset_pulse (rst_pulse)
	);

	// power-up and reset sequencing
	always_comb
	begin
		state_next     = state_reg;
		cnt_next       = cnt_reg;
		not_ready_next = not_ready_reg;
		done_int_next  = done_int_reg;
		init_sw_next   = init_sw_reg;
		defaults_next  = 1'b0;
		if (i_fault)
			done_int_next = 1'b1;
		else if (i_status_read)
			done_int_next = 1'b0;
		unique case (state_reg)
			msbc_pkg::MSBC_ST_RESET:
			begin
				defaults_next  = 1'b1;
				not_ready_next = 1'b1;
				cnt_next       = '0;
				state_next     = msbc_pkg::MSBC_ST_INIT;
			end
			msbc_pkg::MSBC_ST_INIT:
			begin
				cnt_next = cnt_reg + 16'h0001;
				if (cnt_reg >= MGMT_INIT_CYC[msbc_pkg::CNT_W-1:0] - 16'h0001)
				begin
					not_ready_next = 1'b0;
					done_int_next  = 1'b1;
					// undriven select reads as software control
					init_sw_next   = ini_sync_reg[1] | ~drv_sync_reg[1];
					// hardware control goes straight to high power
					if (ini_sync_reg[1] | ~drv_sync_reg[1])
						state_next = msbc_pkg::MSBC_ST_LOWPWR;
					else
						state_next = msbc_pkg::MSBC_ST_HIGHPWR;
				end
			end
			msbc_pkg::MSBC_ST_LOWPWR:
			begin
				if (i_sw_high_power)
					state_next = msbc_pkg::MSBC_ST_HIGHPWR;
			end
			msbc_pkg::MSBC_ST_HIGHPWR:
			begin
				if (init_sw_reg && !i_sw_high_power)
					state_next = msbc_pkg::MSBC_ST_LOWPWR;
			end
			default:
				state_next = msbc_pkg::MSBC_ST_RESET;
		endcase
		if (rst_pulse)
			state_next = msbc_pkg::MSBC_ST_RESET;
		// status and power flags follow the next state, so outputs leave flops
		hp_next     = (state_next == msbc_pkg::MSBC_ST_HIGHPWR);
		status_next = '0;
		status_next[msbc_pkg::STAT_NOT_READY]  = not_ready_next;
		status_next[msbc_pkg::STAT_HIGH_POWER] = hp_next;
		status_next[msbc_pkg::STAT_INIT_SW]    = init_sw_next;
	end

	// asynchronous reset enters reset state, so power-up posts completion
	always_ff @(posedge i_sys_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			state_reg     <= msbc_pkg::MSBC_ST_RESET;
			cnt_reg       <= '0;
			not_ready_reg <= 1'b1;
			done_int_reg  <= 1'b0;
			init_sw_reg   <= msbc_pkg::STAT_RST[msbc_pkg::STAT_INIT_SW];
			defaults_reg  <= 1'b0;
			status_reg    <= msbc_pkg::STAT_RST;
			hp_reg        <= 1'b0;
		end
		else
		begin
			state_reg     <= state_next;
			cnt_reg       <= cnt_next;
			not_ready_reg <= not_ready_next;
			done_int_reg  <= done_int_next;
			init_sw_reg   <= init_sw_next;
			defaults_reg  <= defaults_next;
			status_reg    <= status_next;
			hp_reg        <= hp_next;
		end
	end

	// output drive
	always_comb
	begin
		// bus drivers enabled only while selected
		bus_en_next = ~sel_sync_reg[1] & ~sel_sync_reg[2];
		int_oe_next = done_int_reg;
	end

	always_ff @(posedge i_sys_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			bus_en_reg <= 1'b0;
			int_oe_reg <= 1'b0;
		end
		else
		begin
			bus_en_reg <= bus_en_next;
			int_oe_reg <= int_oe_next;
		end
	end

	assign o_scl_enable        = bus_en_reg;
	assign o_sda_enable        = bus_en_reg;
	assign o_status            = status_reg;
	assign o_high_power        = hp_reg;
	// present line always pulled to ground
	assign o_module_present_n  = 1'b0;
	assign o_module_present_oe = 1'b1;
	assign o_interrupt_n       = 1'b0;
	assign o_interrupt_oe      = int_oe_reg;
	assign o_defaults_load     = defaults_reg;

	// checks
	property p_bus_select;
		@(posedge i_sys_clk) disable iff (!i_nrst)
		sel_sync_reg[2] |=> !o_scl_enable;
	endproperty
	a_bus_select: assert property (p_bus_select) else $error("bus enabled unselected");

	property p_reset_defaults;
		@(posedge i_sys_clk) disable iff (!i_nrst)
		rst_pulse |=> ##1 o_defaults_load && o_status[0];
	endproperty
	a_reset_defaults: assert property (p_reset_defaults) else $error("no defaults");

	property p_done_int;
		@(posedge i_sys_clk) disable iff (!i_nrst)
		$fell(not_ready_reg) |=> int_oe_reg;
	endproperty
	a_done_int: assert property (p_done_int) else $error("no completion irq");

	property p_powerup;
		@(posedge i_sys_clk) disable iff (!i_nrst)
		(state_reg == msbc_pkg::MSBC_ST_RESET) |-> ##[1:1000] !not_ready_reg;
	endproperty
	a_powerup: assert property (p_powerup) else $error("init never done");

	property p_sw_lowpwr;
		@(posedge i_sys_clk) disable iff (!i_nrst)
		(state_reg == msbc_pkg::MSBC_ST_LOWPWR && !i_sw_high_power) |=> !o_high_power;
	endproperty
	a_sw_lowpwr: assert property (p_sw_lowpwr) else $error("left low power");

	property p_hw_highpwr;
		@(posedge i_sys_clk) disable iff (!i_nrst)
		$fell(not_ready_reg) && !init_sw_reg |-> o_high_power;
	endproperty
	a_hw_highpwr: assert property (p_hw_highpwr) else $error("hw init no power");

	property p_undriven;
		@(posedge i_sys_clk) disable iff (!i_nrst)
		$fell(not_ready_reg) && !$past(drv_sync_reg[1]) |-> init_sw_reg;
	endproperty
	a_undriven: assert property (p_undriven) else $error("undriven not sw");

	property p_present;
		@(posedge i_sys_clk) disable iff (!i_nrst)
		o_module_present_oe && !o_module_present_n;
	endproperty
	a_present: assert property (p_present) else $error("not present");

	property p_fault_int;
		@(posedge i_sys_clk) disable iff (!i_nrst)
		i_fault |=> ##1 o_interrupt_oe;
	endproperty
	a_fault_int: assert property (p_fault_int) else $error("fault no irq");

	property p_open_drain;
		@(posedge i_sys_clk) disable iff (!i_nrst)
		o_interrupt_oe |-> !o_interrupt_n;
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("irq driven high");

	property p_glitch;
		@(posedge i_sys_clk) disable iff (!i_nrst)
		rst_pulse |-> low_run_reg >= RST_MIN_CYC[msbc_pkg::CNT_W-1:0];
	endproperty
	a_glitch: assert property (p_glitch) else $error("glitch reset");

	c_reset: cover property (@(posedge i_sys_clk) rst_pulse);
	c_hipwr: cover property (@(posedge i_sys_clk) $rose(o_high_power));
	c_fault: cover property (@(posedge i_sys_clk) i_fault);
	c_sel_frame: cover property (@(posedge i_sys_clk) o_scl_enable && $fell(scl_sync_reg[1]));
	c_start: cover property (@(posedge i_sys_clk) $fell(sda_sync_reg[1]) && scl_sync_reg[1]);
endmodule // msbc_sideband

// File: testbench/msbc_host_model.sv
// host board model: module select line and serial bus master frames
module msbc_host_model (
	input  wire logic i_select_req,
	input  wire logic i_frame_req,
	output logic      o_module_select_n,
	output logic      o_scl,
	output logic      o_sda,
	output logic      o_frame_busy
);
	timeunit 1ns;
	timeprecision 1ns;
	assign o_module_select_n = ~i_select_req;
	// nine-bit frame at 800 ns per bit, clock stands high between frames
	initial
	begin
		o_scl = 1'b1;
		o_sda = 1'b1;
		o_frame_busy = 1'b0;
		forever
		begin
			@(posedge i_frame_req);
			#37 o_frame_busy = 1'b1;
			o_sda = 1'b0; // start while clock high
			repeat (9)
			begin
				#200 o_scl = 1'b0;
				#200 o_sda = ~o_sda;
				#400 o_scl = 1'b1;
			end
			// stop: data low under a low clock, then rises while clock is high
			#200 o_scl = 1'b0;
			#200 o_sda = 1'b0;
			#200 o_scl = 1'b1;
			#200 o_sda = 1'b1; // released line goes to pull-up
			o_frame_busy = 1'b0;
		end
	end
endmodule // msbc_host_model

// File: testbench/tb_top.sv
// self-checking bench of the module sideband control block
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic       i_sys_clk = 1'b0;
	logic       nrst      = 1'b0;
	logic       sel_req   = 1'b0;
	logic       frame_req = 1'b0;
	logic       rst_pin   = 1'b1;
	logic       init_sel  = 1'b1;
	logic       init_drv  = 1'b0;
	logic       sw_hp     = 1'b0;
	logic       fault     = 1'b0;
	logic       st_read   = 1'b0;
	logic       sel_n, scl, sda, busy;
	logic       scl_en, sda_en, hp, prs_n, prs_oe, int_n, int_oe, dload;
	logic [7:0] status;
	int         miscompares = 0;
	int         checked = 0;
	int         cycles = 0;
	int         loads = 0;
	int         l0;

	msbc_host_model u_host (.i_select_req(sel_req), .i_frame_req(frame_req),
		.o_module_select_n(sel_n), .o_scl(scl), .o_sda(sda), .o_frame_busy(busy));

	msbc_sideband u_dut (.i_sys_clk(i_sys_clk), .i_nrst(nrst), .i_module_select_n(sel_n),
		.i_module_reset_n(rst_pin), .i_init_control_select(init_sel),
		.i_init_select_driven(init_drv), .i_scl(scl), .i_sda(sda),
		.i_sw_high_power(sw_hp), .i_fault(fault), .i_status_read(st_read),
		.o_scl_enable(scl_en), .o_sda_enable(sda_en), .o_status(status),
		.o_high_power(hp), .o_module_present_n(prs_n), .o_module_present_oe(prs_oe),
		.o_interrupt_n(int_n), .o_interrupt_oe(int_oe), .o_defaults_load(dload));

	// system clock, 100 ns period
	always #50 i_sys_clk = ~i_sys_clk;

	// count default-restore pulses
	always @(posedge i_sys_clk)
		if (dload === 1'b1)
			loads++;

	// cycle ceiling cuts a hang short
	always @(posedge i_sys_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			miscompares++;
			conclude();
		end
	end

	task automatic check(input logic got, input logic exp, input string msg);
		checked++;
		if (got !== exp)
		begin
			$display("MISMATCH %0t %s", $time, msg);
			miscompares++;
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge i_sys_clk);
	endtask

	task automatic wait_int(input logic v, input int n);
		for (int i = 0; i < n && int_oe !== v; i++) @(negedge i_sys_clk);
	endtask

	task automatic wait_hp(input logic v, input int n);
		for (int i = 0; i < n && hp !== v; i++) @(negedge i_sys_clk);
	endtask

	task automatic pulse(input logic f, input logic r);
		@(posedge i_sys_clk);
		fault <= f;
		st_read <= r;
		@(posedge i_sys_clk);
		fault <= 1'b0;
		st_read <= 1'b0;
		cyc(3);
	endtask

	task automatic pin_low(input int n);
		@(posedge i_sys_clk);
		rst_pin <= 1'b0;
		repeat (n) @(posedge i_sys_clk);
		rst_pin <= 1'b1;
	endtask

	task automatic run_frame;
		@(posedge i_sys_clk);
		frame_req <= 1'b1;
		for (int i = 0; i < 5 && busy !== 1'b1; i++) @(negedge i_sys_clk);
		@(posedge i_sys_clk);
		frame_req <= 1'b0;
		for (int i = 0; i < 100 && busy !== 1'b0; i++) @(negedge i_sys_clk);
		check(busy, 1'b0, "host frame hung");
	endtask

	task automatic t_powerup;
		wait_int(1'b1, 120);
		check(int_oe, 1'b1, "no completion interrupt after power-up");
		check(status[msbc_pkg::STAT_NOT_READY], 1'b0, "not ready still set");
		check(int_n, 1'b0, "interrupt pin level not low");
		check(prs_n === 1'b0 && prs_oe === 1'b1, 1'b1, "present not grounded");
		check(status[msbc_pkg::STAT_INIT_SW], 1'b1, "undriven init select low");
	endtask

	task automatic t_select;
		run_frame();
		check(scl_en | sda_en, 1'b0, "bus answered while deselected");
		@(posedge i_sys_clk);
		sel_req <= 1'b1;
		cyc(5);
		check(scl_en & sda_en, 1'b1, "bus closed while selected");
		run_frame();
		check(sda_en, 1'b1, "bus dropped during frame");
		@(posedge i_sys_clk);
		sel_req <= 1'b0;
		cyc(4);
		check(scl_en, 1'b0, "bus open after deselect");
	endtask

	task automatic t_interrupt;
		pulse(1'b0, 1'b1); // host reads status after interrupt
		check(int_oe, 1'b0, "read kept interrupt");
		pulse(1'b1, 1'b0);
		check(int_oe, 1'b1, "fault not flagged");
		pulse(1'b0, 1'b1);
		pulse(1'b1, 1'b1);
		check(int_oe, 1'b1, "read beat same-cycle fault");
		pulse(1'b0, 1'b1);
	endtask

	task automatic t_short_reset;
		l0 = loads;
		pin_low(18);
		cyc(40);
		check(loads == l0, 1'b1, "short reset acted");
		check(int_oe, 1'b0, "short reset raised interrupt");
	endtask

	task automatic t_sw_mode;
		l0 = loads;
		pin_low(30);
		cyc(10);
		check(loads == l0 + 1, 1'b1, "long reset gave no restore");
		check(status[msbc_pkg::STAT_NOT_READY], 1'b1, "not ready not restored");
		wait_int(1'b1, 120); // status ignored until completion
		check(int_oe, 1'b1, "no completion interrupt");
		check(status[msbc_pkg::STAT_NOT_READY], 1'b0, "not ready kept");
		cyc(20);
		check(hp, 1'b0, "high power without software");
		@(posedge i_sys_clk);
		sw_hp <= 1'b1;
		wait_hp(1'b1, 10);
		check(status[msbc_pkg::STAT_HIGH_POWER], 1'b1, "software enable ignored");
		@(posedge i_sys_clk);
		sw_hp <= 1'b0;
		wait_hp(1'b0, 10);
		check(hp, 1'b0, "high power kept after disable");
	endtask

	task automatic t_hw_mode;
		@(posedge i_sys_clk);
		nrst <= 1'b0; // init select changed only across re-insertion
		init_drv <= 1'b1;
		init_sel <= 1'b0;
		cyc(3);
		@(posedge i_sys_clk);
		nrst <= 1'b1;
		wait_hp(1'b1, 120);
		check(hp, 1'b1, "hardware init stayed low power");
		check(status[msbc_pkg::STAT_INIT_SW], 1'b0, "init mode bit wrong");
		wait_int(1'b1, 10);
		check(int_oe, 1'b1, "no interrupt after re-insertion");
	endtask

	task automatic conclude;
		$display("checks %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// main sequence
	initial
	begin
		repeat (10) @(posedge i_sys_clk);
		nrst <= 1'b1;
		t_powerup();
		t_select();
		t_interrupt();
		t_short_reset();
		t_sw_mode();
		t_hw_mode();
		conclude();
	end
endmodule // tb_top
